// ==== design/cbe_pkg.sv ====
/*
 * Shared constants for the break-entry and instruction-subset core:
 * opcodes, vectors, flag positions, reset values and sequencer states.
 * Assumes an 8-bit data, 16-bit address core with one clock.
 */
package cbe_pkg;

  // Opcodes handled by the core
  localparam logic [7:0] OP_ADC_IMM   = 8'hA9;
  localparam logic [7:0] OP_ADD_IMM   = 8'hAB;
  localparam logic [7:0] OP_PREFIX    = 8'h9E;
  localparam logic [7:0] OP_ADC_SP2   = 8'hD9;
  localparam logic [7:0] OP_ADD_SP2   = 8'hDB;
  localparam logic [7:0] OP_STK_SADD  = 8'hA7;
  localparam logic [7:0] OP_IDX_SADD  = 8'hAF;
  localparam logic [7:0] OP_BR_CC     = 8'h24;
  localparam logic [7:0] OP_BR_CS     = 8'h25;
  localparam logic [7:0] OP_BR_ZS     = 8'h27;
  localparam logic [7:0] OP_RET_TRAP  = 8'h80;
  localparam logic [7:0] OP_SOFT_TRAP = 8'h83;

  // Vectors
  localparam logic [15:0] VEC_RESET   = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP    = 16'hFFFC;
  localparam logic [15:0] VEC_TRAP_MON = 16'hFEFC;

  // Condition flag bit positions
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_ONES  = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;

  // Reset values and stack frame
  localparam logic [15:0] SP_RESET    = 16'h00FF;
  localparam logic [15:0] ONE16       = 16'h0001;
  localparam logic [2:0]  FRAME_LAST  = 3'h4;
  localparam logic [2:0]  FRM_PCL     = 3'h0;
  localparam logic [2:0]  FRM_PCH     = 3'h1;
  localparam logic [2:0]  FRM_X       = 3'h2;
  localparam logic [2:0]  FRM_A       = 3'h3;

  // Sequencer states, Gray along fetch, operand, branch
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_OPND  = 4'h1,
    ST_BRCH  = 4'h3,
    ST_PFX   = 4'h2,
    ST_OFSH  = 4'h6,
    ST_OFSL  = 4'h7,
    ST_MEMRD = 4'h5,
    ST_PUSH  = 4'h4,
    ST_VECH  = 4'hC,
    ST_VECL  = 4'hD,
    ST_PULL  = 4'hF
  } cbe_state_t;

endpackage

// ==== design/cbe_add8.sv ====
/*
 * Eight-bit adder with optional carry in and the five arithmetic flags.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
`default_nettype none

module cbe_add8 (
  // Operands
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       cin_i,
  // Result and flags
  output logic      [7:0] sum_o,
  output logic            v_o,
  output logic            h_o,
  output logic            n_o,
  output logic            z_o,
  output logic            c_o
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    low   = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    sum_o = full[7:0];
    c_o   = full[8];
    h_o   = low[4];
    n_o   = full[7];
    z_o   = (full[7:0] == 8'h00);
    // Same-sign operands giving other-sign result
    v_o   = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
  end

endmodule

`default_nettype wire

// ==== design/cbe_sext_add.sv ====
/*
 * Adds a sign-extended 8-bit value to a 16-bit base.
 * Combinational; shared by stack, index and branch target arithmetic.
 */
`timescale 1ns/1ps
`default_nettype none

module cbe_sext_add (
  // Operands
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  imm_i,
  // Result
  output logic      [15:0] sum_o
);

  always_comb begin
    sum_o = base_i + {{8{imm_i[7]}}, imm_i};
  end

endmodule

`default_nettype wire

// ==== design/cbe_core.sv ====
/*
 * Core sequencer: break entry, trap entry and return, add with and
 * without carry (immediate and 16-bit stack offset), signed adds to the
 * stack pointer and index pair, and carry/zero branches.
 * Assumes a memory whose read data is valid in the same cycle as the
 * registered address, and a break source that keeps its request high
 * until entry begins.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Break entry loads the soft trap opcode into the instruction register instead of fetching.
// - Break entry loads the program counter from FFFC:FFFD, or FEFC:FEFD in monitor mode.
// - Break entry waits until the instruction in progress has completed.
// - A break request seen on an instruction's last cycle starts entry at the next boundary.
// - Return from trap in the break handler ends break once the request has been withdrawn.
// - Add with carry sets A to A plus operand plus C and updates V, H, N, Z and C.
// - Opcode A7 adds a sign-extended immediate to the stack pointer in 2 cycles, no flags.
// - Opcode AF adds a sign-extended immediate to the index pair in 2 cycles, no flags.
// - Opcode 24 branches to its address plus 2 plus offset when C is clear, in 3 cycles.
// - Opcode 25 branches when C is set, in 3 cycles, and otherwise falls through.
// - Opcode 27 branches to its address plus 2 plus offset when Z is set.
// - Half carry is set by a carry from bit 3 into bit 4 of an add, else cleared.
// - Trap entry sets the interrupt mask after stacking and before the vector read.
module cbe_core (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Memory bus
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Break module
  input  wire logic        brk_req_i,
  input  wire logic        monitor_mode_i,
  output logic             brk_active_o,
  // Architectural state and instruction-done strobe
  output logic      [7:0]  acc_o,
  output logic      [15:0] index_pair_o,
  output logic      [15:0] stack_pointer_o,
  output logic      [15:0] pc_o,
  output logic      [7:0]  condition_flags_o,
  output logic             insn_done_o
);

  cbe_pkg::cbe_state_t state_r, state_nxt;
  logic [7:0]  ir_r, ir_nxt;
  logic [7:0]  acc_r, acc_nxt;
  logic [15:0] hx_r, hx_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  ccr_r, ccr_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic        brk_r, brk_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic        rd_r, rd_nxt;
  logic        wr_r, wr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        done_r, done_nxt;

  logic [7:0]  alu_sum;
  logic        alu_v, alu_h, alu_n, alu_z, alu_c;
  logic        alu_cin;
  logic [15:0] sadd_base;
  logic [15:0] sadd_sum;

  // Flags after an add; I and the fixed ones are kept
  function automatic logic [7:0] add_flags(input logic [7:0] f, input logic v, input logic h,
                                           input logic n, input logic z, input logic c);
    logic [7:0] r;
    r = f;
    r[cbe_pkg::FLG_V] = v;
    r[cbe_pkg::FLG_H] = h;
    r[cbe_pkg::FLG_N] = n;
    r[cbe_pkg::FLG_Z] = z;
    r[cbe_pkg::FLG_C] = c;
    return r;
  endfunction

  function automatic logic is_add_op(input logic [7:0] op);
    return (op == cbe_pkg::OP_ADC_IMM) || (op == cbe_pkg::OP_ADD_IMM) ||
           (op == cbe_pkg::OP_ADC_SP2) || (op == cbe_pkg::OP_ADD_SP2);
  endfunction

  function automatic logic is_branch(input logic [7:0] op);
    return (op == cbe_pkg::OP_BR_CC) || (op == cbe_pkg::OP_BR_CS) ||
           (op == cbe_pkg::OP_BR_ZS);
  endfunction

  function automatic logic branch_taken(input logic [7:0] op, input logic [7:0] f);
    logic t;
    t = 1'b0;
    if (op == cbe_pkg::OP_BR_CC) begin
      t = !f[cbe_pkg::FLG_C];
    end else if (op == cbe_pkg::OP_BR_CS) begin
      t = f[cbe_pkg::FLG_C];
    end else if (op == cbe_pkg::OP_BR_ZS) begin
      t = f[cbe_pkg::FLG_Z];
    end
    return t;
  endfunction

  // Stacking order: PCL, PCH, X, A, flags
  function automatic logic [7:0] frame_byte(input logic [2:0] idx, input logic [15:0] pc,
                                            input logic [15:0] hx, input logic [7:0] a,
                                            input logic [7:0] f);
    logic [7:0] b;
    b = f;
    if (idx == cbe_pkg::FRM_PCL) begin
      b = pc[7:0];
    end else if (idx == cbe_pkg::FRM_PCH) begin
      b = pc[15:8];
    end else if (idx == cbe_pkg::FRM_X) begin
      b = hx[7:0];
    end else if (idx == cbe_pkg::FRM_A) begin
      b = a;
    end
    return b;
  endfunction

  // Carry in only for the with-carry opcodes
  assign alu_cin = ((ir_r == cbe_pkg::OP_ADC_IMM) || (ir_r == cbe_pkg::OP_ADC_SP2)) ?
                   ccr_r[cbe_pkg::FLG_C] : 1'b0;

  cbe_add8 u_add8 (
    .a_i   (acc_r),
    .b_i   (mem_rdata_i),
    .cin_i (alu_cin),
    .sum_o (alu_sum),
    .v_o   (alu_v),
    .h_o   (alu_h),
    .n_o   (alu_n),
    .z_o   (alu_z),
    .c_o   (alu_c)
  );

  // Branch base is the byte after the offset, i.e. opcode address plus 2
  always_comb begin
    if (ir_r == cbe_pkg::OP_STK_SADD) begin
      sadd_base = sp_r;
    end else if (ir_r == cbe_pkg::OP_IDX_SADD) begin
      sadd_base = hx_r;
    end else begin
      sadd_base = pc_r + cbe_pkg::ONE16;
    end
  end

  cbe_sext_add u_sadd (
    .base_i (sadd_base),
    .imm_i  (mem_rdata_i),
    .sum_o  (sadd_sum)
  );

  always_comb begin
    state_nxt = state_r;
    ir_nxt    = ir_r;
    acc_nxt   = acc_r;
    hx_nxt    = hx_r;
    sp_nxt    = sp_r;
    pc_nxt    = pc_r;
    ccr_nxt   = ccr_r;
    ofs_nxt   = ofs_r;
    vec_nxt   = vec_r;
    cnt_nxt   = cnt_r;
    brk_nxt   = brk_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      cbe_pkg::ST_FETCH: begin
        // Only reached at an instruction boundary
        if (brk_req_i && !brk_r) begin
          ir_nxt    = cbe_pkg::OP_SOFT_TRAP;
          brk_nxt   = 1'b1;
          cnt_nxt   = cbe_pkg::FRM_PCL;
          state_nxt = cbe_pkg::ST_PUSH;
        end else begin
          ir_nxt = mem_rdata_i;
          pc_nxt = pc_r + cbe_pkg::ONE16;
          if (mem_rdata_i == cbe_pkg::OP_PREFIX) begin
            state_nxt = cbe_pkg::ST_PFX;
          end else if (mem_rdata_i == cbe_pkg::OP_SOFT_TRAP) begin
            cnt_nxt   = cbe_pkg::FRM_PCL;
            state_nxt = cbe_pkg::ST_PUSH;
          end else if (mem_rdata_i == cbe_pkg::OP_RET_TRAP) begin
            cnt_nxt   = cbe_pkg::FRM_PCL;
            sp_nxt    = sp_r + cbe_pkg::ONE16;
            state_nxt = cbe_pkg::ST_PULL;
          end else if ((mem_rdata_i == cbe_pkg::OP_ADC_IMM) ||
                       (mem_rdata_i == cbe_pkg::OP_ADD_IMM) || is_branch(mem_rdata_i) ||
                       (mem_rdata_i == cbe_pkg::OP_STK_SADD) ||
                       (mem_rdata_i == cbe_pkg::OP_IDX_SADD)) begin
            state_nxt = cbe_pkg::ST_OPND;
          end else begin
            // Unsupported opcodes pass as one-cycle no-ops
            done_nxt = 1'b1;
          end
        end
      end
      cbe_pkg::ST_OPND: begin
        pc_nxt    = pc_r + cbe_pkg::ONE16;
        state_nxt = cbe_pkg::ST_FETCH;
        done_nxt  = 1'b1;
        if (is_add_op(ir_r)) begin
          acc_nxt = alu_sum;
          ccr_nxt = add_flags(ccr_r, alu_v, alu_h, alu_n, alu_z, alu_c);
        end else if (ir_r == cbe_pkg::OP_STK_SADD) begin
          sp_nxt = sadd_sum;
        end else if (ir_r == cbe_pkg::OP_IDX_SADD) begin
          hx_nxt = sadd_sum;
        end else begin
          ofs_nxt   = sadd_sum;
          done_nxt  = 1'b0;
          state_nxt = cbe_pkg::ST_BRCH;
        end
      end
      cbe_pkg::ST_BRCH: begin
        if (branch_taken(ir_r, ccr_r)) begin
          pc_nxt = ofs_r;
        end
        done_nxt  = 1'b1;
        state_nxt = cbe_pkg::ST_FETCH;
      end
      cbe_pkg::ST_PFX: begin
        ir_nxt = mem_rdata_i;
        pc_nxt = pc_r + cbe_pkg::ONE16;
        if ((mem_rdata_i == cbe_pkg::OP_ADC_SP2) || (mem_rdata_i == cbe_pkg::OP_ADD_SP2)) begin
          state_nxt = cbe_pkg::ST_OFSH;
        end else begin
          done_nxt  = 1'b1;
          state_nxt = cbe_pkg::ST_FETCH;
        end
      end
      cbe_pkg::ST_OFSH: begin
        ofs_nxt[15:8] = mem_rdata_i;
        pc_nxt        = pc_r + cbe_pkg::ONE16;
        state_nxt     = cbe_pkg::ST_OFSL;
      end
      cbe_pkg::ST_OFSL: begin
        ofs_nxt[7:0] = mem_rdata_i;
        pc_nxt       = pc_r + cbe_pkg::ONE16;
        state_nxt    = cbe_pkg::ST_MEMRD;
      end
      cbe_pkg::ST_MEMRD: begin
        acc_nxt   = alu_sum;
        ccr_nxt   = add_flags(ccr_r, alu_v, alu_h, alu_n, alu_z, alu_c);
        done_nxt  = 1'b1;
        state_nxt = cbe_pkg::ST_FETCH;
      end
      cbe_pkg::ST_PUSH: begin
        sp_nxt = sp_r - cbe_pkg::ONE16;
        if (cnt_r == cbe_pkg::FRAME_LAST) begin
          ccr_nxt[cbe_pkg::FLG_I] = 1'b1;
          vec_nxt   = monitor_mode_i ? cbe_pkg::VEC_TRAP_MON : cbe_pkg::VEC_TRAP;
          state_nxt = cbe_pkg::ST_VECH;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      cbe_pkg::ST_VECH: begin
        pc_nxt[15:8] = mem_rdata_i;
        state_nxt    = cbe_pkg::ST_VECL;
      end
      cbe_pkg::ST_VECL: begin
        pc_nxt[7:0] = mem_rdata_i;
        done_nxt    = 1'b1;
        state_nxt   = cbe_pkg::ST_FETCH;
      end
      cbe_pkg::ST_PULL: begin
        // Pull order: flags, A, X, PCH, PCL
        if (cnt_r == cbe_pkg::FRM_PCL) begin
          ccr_nxt = mem_rdata_i | cbe_pkg::FLAGS_ONES;
        end else if (cnt_r == cbe_pkg::FRM_PCH) begin
          acc_nxt = mem_rdata_i;
        end else if (cnt_r == cbe_pkg::FRM_X) begin
          hx_nxt[7:0] = mem_rdata_i;
        end else if (cnt_r == cbe_pkg::FRM_A) begin
          pc_nxt[15:8] = mem_rdata_i;
        end else begin
          pc_nxt[7:0] = mem_rdata_i;
        end
        if (cnt_r == cbe_pkg::FRAME_LAST) begin
          // A request still held keeps break active and blocks re-entry
          if (!brk_req_i) begin
            brk_nxt = 1'b0;
          end
          done_nxt  = 1'b1;
          state_nxt = cbe_pkg::ST_FETCH;
        end else begin
          sp_nxt  = sp_r + cbe_pkg::ONE16;
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      default: begin
        state_nxt = cbe_pkg::ST_FETCH;
      end
    endcase

    // Bus cycle of the coming state
    addr_nxt  = pc_nxt;
    rd_nxt    = 1'b1;
    wr_nxt    = 1'b0;
    wdata_nxt = wdata_r;
    unique case (state_nxt)
      cbe_pkg::ST_MEMRD: addr_nxt = sp_nxt + ofs_nxt;
      cbe_pkg::ST_PULL:  addr_nxt = sp_nxt;
      cbe_pkg::ST_VECH:  addr_nxt = vec_nxt;
      cbe_pkg::ST_VECL:  addr_nxt = vec_nxt + cbe_pkg::ONE16;
      cbe_pkg::ST_BRCH: begin
        rd_nxt = 1'b0;
      end
      cbe_pkg::ST_PUSH: begin
        addr_nxt  = sp_nxt;
        rd_nxt    = 1'b0;
        wr_nxt    = 1'b1;
        wdata_nxt = frame_byte(cnt_nxt, pc_nxt, hx_nxt, acc_nxt, ccr_nxt);
      end
      default: begin
        addr_nxt = pc_nxt;
      end
    endcase
  end

  // Reset starts at the reset vector read
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= cbe_pkg::ST_VECH;
      ir_r    <= 8'h00;
      acc_r   <= 8'h00;
      hx_r    <= 16'h0000;
      sp_r    <= cbe_pkg::SP_RESET;
      pc_r    <= 16'h0000;
      ccr_r   <= cbe_pkg::FLAGS_RESET;
      ofs_r   <= 16'h0000;
      vec_r   <= cbe_pkg::VEC_RESET;
      cnt_r   <= 3'h0;
      brk_r   <= 1'b0;
      addr_r  <= cbe_pkg::VEC_RESET;
      rd_r    <= 1'b1;
      wr_r    <= 1'b0;
      wdata_r <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ir_r    <= ir_nxt;
      acc_r   <= acc_nxt;
      hx_r    <= hx_nxt;
      sp_r    <= sp_nxt;
      pc_r    <= pc_nxt;
      ccr_r   <= ccr_nxt;
      ofs_r   <= ofs_nxt;
      vec_r   <= vec_nxt;
      cnt_r   <= cnt_nxt;
      brk_r   <= brk_nxt;
      addr_r  <= addr_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
    end
  end

  assign mem_addr_o        = addr_r;
  assign mem_rd_o          = rd_r;
  assign mem_wr_o          = wr_r;
  assign mem_wdata_o       = wdata_r;
  assign brk_active_o      = brk_r;
  assign acc_o             = acc_r;
  assign index_pair_o      = hx_r;
  assign stack_pointer_o   = sp_r;
  assign pc_o              = pc_r;
  assign condition_flags_o = ccr_r;
  assign insn_done_o       = done_r;

endmodule

`default_nettype wire

// ==== tb/cbe_monitor.sv ====
/* Checker on cbe_core ports: adds, branches, break entry and exit.
   Assumes it is bound to cbe_core and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module cbe_monitor (
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        brk_req_i,
  input wire logic        monitor_mode_i,
  input wire logic        brk_active_o,
  input wire logic [7:0]  acc_o,
  input wire logic [15:0] index_pair_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [7:0]  condition_flags_o,
  input wire logic        insn_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic        fetch, fd_r, cin, tk, is_add, is_br;
  logic [7:0]  op_r, opd_r, acc_r, flg_r;
  logic [15:0] adr_r, sp_r, hx_r, sx;
  logic [8:0]  sum;
  logic [4:0]  hs;
  // A fetch discarded for break entry carries no opcode
  assign fetch = insn_done_o && !(brk_req_i && !brk_active_o);
  assign is_add = fetch && (mem_rdata_i == cbe_pkg::OP_ADC_IMM || mem_rdata_i == cbe_pkg::OP_ADD_IMM);
  assign is_br = fetch && (mem_rdata_i inside {cbe_pkg::OP_BR_CC, cbe_pkg::OP_BR_CS,
                                                cbe_pkg::OP_BR_ZS});
  assign cin = (op_r == cbe_pkg::OP_ADC_IMM) && flg_r[0];
  assign sum = {1'h0, acc_r} + {1'h0, opd_r} + {8'h00, cin};
  assign hs = {1'h0, acc_r[3:0]} + {1'h0, opd_r[3:0]} + {4'h0, cin};
  assign sx = {{8{opd_r[7]}}, opd_r};
  assign tk = (op_r == cbe_pkg::OP_BR_CC) ? !flg_r[0] :
              (op_r == cbe_pkg::OP_BR_CS) ? flg_r[0] : flg_r[1];
  always_ff @(posedge core_clk_i) begin
    fd_r <= fetch;
    if (fetch) begin
      op_r <= mem_rdata_i;
      adr_r <= mem_addr_o;
      acc_r <= acc_o;
      flg_r <= condition_flags_o;
      sp_r <= stack_pointer_o;
      hx_r <= index_pair_o;
    end
    if (fd_r) begin
      opd_r <= mem_rdata_i;
    end
  end
  AST_ADD_RESULT: assert property (is_add |-> ##2 insn_done_o && acc_o == sum[7:0] &&
    condition_flags_o[0] == sum[8] && condition_flags_o[1] == (sum[7:0] == 8'h00))
    else $error("add result or carry wrong");
  AST_ADD_HALF: assert property (is_add |-> ##2 condition_flags_o[4] == hs[4])
    else $error("half carry wrong");
  AST_STK_ADD: assert property (fetch && mem_rdata_i == cbe_pkg::OP_STK_SADD |->
    ##2 insn_done_o && stack_pointer_o == sp_r + sx && condition_flags_o == flg_r)
    else $error("stack pointer add wrong");
  AST_IDX_ADD: assert property (fetch && mem_rdata_i == cbe_pkg::OP_IDX_SADD |->
    ##2 insn_done_o && index_pair_o == hx_r + sx && condition_flags_o == flg_r)
    else $error("index pair add wrong");
  AST_BRANCH: assert property (is_br |-> ##2 !insn_done_o ##1 insn_done_o &&
    condition_flags_o == flg_r && mem_addr_o == adr_r + 16'h0002 + (tk ? sx : 16'h0000))
    else $error("branch target or length wrong");
  AST_BRK_DEFER: assert property (is_br |-> ##1 (!brk_active_o && !mem_wr_o) [*3])
    else $error("break began inside an instruction");
  AST_BRK_NOW: assert property (insn_done_o && brk_req_i && !brk_active_o |=>
    brk_active_o && mem_wr_o) else $error("break not begun at boundary");
  AST_BRK_STACK: assert property ($rose(brk_active_o) |-> mem_wr_o [*5] ##1
    condition_flags_o[cbe_pkg::FLG_I]) else $error("stacking or mask wrong");
  AST_BRK_VEC: assert property ($rose(brk_active_o) |-> ##5 mem_addr_o ==
    ($past(monitor_mode_i) ? cbe_pkg::VEC_TRAP_MON : cbe_pkg::VEC_TRAP))
    else $error("break vector wrong");
  AST_BRK_END: assert property ($fell(brk_active_o) |-> insn_done_o && !$past(brk_req_i))
    else $error("break ended wrongly");
  CV_BRK_IN: cover property ($rose(brk_active_o));
  CV_BRK_OUT: cover property ($fell(brk_active_o));
  CV_TAKEN: cover property (is_br ##1 tk);
endmodule
`default_nettype wire

// ==== tb/cbe_brk_mem.sv ====
/* Far side of cbe_core: async-read memory and the break request source.
   Assumes the bench preloads mem and pulses arm_i to ask for a break. */
`timescale 1ns/1ps
`default_nettype none
module cbe_brk_mem (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        arm_i,
  input  wire logic        active_i,
  output logic      [7:0]  rdata_o,
  output logic             req_o
);
  logic [7:0] mem [65536];
  // Idle bus shows inverted byte so stale data cannot pass
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
  initial req_o = 1'h0;
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    if (active_i) req_o <= 1'h0;
    else if (arm_i) req_o <= 1'h1;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/* Self-checking bench for cbe_core: random add/branch stream, then breaks.
   Assumes cbe_brk_mem as memory and break source, cbe_monitor bound below. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        mon = 1'h0;
  logic        arm = 1'h0;
  logic        mem_rd_o, mem_wr_o, brk_active_o, insn_done_o, req;
  logic [15:0] mem_addr_o, index_pair_o, stack_pointer_o, pc_o;
  logic [7:0]  mem_wdata_o, rdata, acc_o, condition_flags_o;
  int          miscompares = 0;
  int          checks = 0;
  int          n, ecyc, scyc;
  logic [15:0] epc, esp, ehx, spc, ssp, shx, hnd;
  logic [7:0]  ea, ef, sa, sf;
  logic [39:0] pk;
  logic [7:0]  ops [10] = '{8'hAB, 8'hA9, 8'hA9, 8'hA7, 8'hAF, 8'h24, 8'h25, 8'h27, 8'hD9, 8'hDB};
  logic [7:0]  cor [10] = '{8'h8F, 8'h71, 8'h7F, 8'h80, 8'hFF, 8'h7F, 8'h05, 8'h10, 8'h05, 8'h03};
  initial forever #20 core_clk_i = ~core_clk_i;
  cbe_core dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(rdata),
    .brk_req_i(req), .monitor_mode_i(mon), .brk_active_o(brk_active_o), .acc_o(acc_o),
    .index_pair_o(index_pair_o), .stack_pointer_o(stack_pointer_o), .pc_o(pc_o),
    .condition_flags_o(condition_flags_o), .insn_done_o(insn_done_o));
  cbe_brk_mem prt (.clk_i(core_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .arm_i(arm), .active_i(brk_active_o), .rdata_o(rdata), .req_o(req));
  function automatic logic [15:0] add_ref(input logic [7:0] a, b, f, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'h0, a} + {1'h0, b} + {8'h00, c};
    h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, c};
    return {(a[7] == b[7]) && (s[7] != a[7]), 2'h3, h[4], f[3], s[7], s[7:0] == 8'h00, s[8],
            s[7:0]};
  endfunction
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_cyc(input int got, exp);
    checks++;
    if (got != exp) begin
      miscompares++;
      $display("FAIL %0t took %0d cycles, expected %0d", $time, got, exp);
    end
  endtask
  task automatic wait_until(input int sel, output int cyc);
    for (cyc = 1; cyc < 64; cyc++) begin
      @(negedge core_clk_i);
      if ((sel == 0 && brk_active_o === 1'h1) || (sel == 2 && brk_active_o === 1'h0) ||
          (sel == 1 && mem_addr_o === hnd && mem_rd_o === 1'h1) ||
          (sel == 3 && insn_done_o === 1'h1)) return;
    end
    miscompares++;
    $display("FAIL %0t wait %0d ran out", $time, sel);
    print_verdict();
  endtask
  // Writes the next instruction ahead of its fetch and steps the model
  task automatic gen(input logic [7:0] op, input logic [7:0] b);
    logic [7:0] d;
    if (op inside {8'hD9, 8'hDB}) begin
      d = b ^ 8'h5A;
      prt.mem[epc] = cbe_pkg::OP_PREFIX;
      prt.mem[epc + 16'h0001] = op;
      prt.mem[epc + 16'h0002] = 8'h00;
      prt.mem[epc + 16'h0003] = b;
      prt.mem[esp + {8'h00, b}] = d;
      {ef, ea} = add_ref(ea, d, ef, op == 8'hD9 && ef[0]);
      epc += 16'h0004;
      ecyc = 5;
      return;
    end
    // Forward branches only, so no write lands on code still to be read
    if (op inside {8'h24, 8'h25, 8'h27}) b &= 8'h7F;
    prt.mem[epc] = op;
    prt.mem[epc + 16'h0001] = b;
    epc += 16'h0002;
    ecyc = 2;
    case (op)
      8'hA9, 8'hAB: {ef, ea} = add_ref(ea, b, ef, op == 8'hA9 && ef[0]);
      8'hA7: esp += sx(b);
      8'hAF: ehx += sx(b);
      default: begin
        ecyc = 3;
        if ((op == 8'h24 && !ef[0]) || (op == 8'h25 && ef[0]) || (op == 8'h27 && ef[1]))
          epc += sx(b);
      end
    endcase
  endtask
  task automatic snap();
    spc = epc;
    ssp = esp;
    shx = ehx;
    sa = ea;
    sf = ef;
    scyc = ecyc;
  endtask
  task automatic step(input logic [7:0] op, input logic [7:0] b);
    snap();
    gen(op, b);
    wait_until(3, n);
    chk_cyc(n, scyc);
    chk(mem_addr_o, spc, "next pc");
    chk(pc_o, spc, "pc");
    chk(stack_pointer_o, ssp, "sp");
    chk(index_pair_o, shx, "hx");
    chk({acc_o, condition_flags_o}, {sa, sf}, "acc and flags");
  endtask
  initial begin
    void'($urandom(47742));
    epc = 16'h8000;
    esp = cbe_pkg::SP_RESET;
    ehx = 16'h0000;
    ea = 8'h00;
    ef = cbe_pkg::FLAGS_RESET;
    hnd = epc;
    prt.mem[16'hFFFE] = 8'h80;
    prt.mem[16'hFFFF] = 8'h00;
    gen(ops[0], cor[0]);
    repeat (5) @(negedge core_clk_i);
    chk(mem_addr_o, cbe_pkg::VEC_RESET, "reset address");
    chk({acc_o, condition_flags_o}, {8'h00, cbe_pkg::FLAGS_RESET}, "reset acc and flags");
    chk(stack_pointer_o, cbe_pkg::SP_RESET, "reset sp");
    rstn_i = 1'h1;
    wait_until(1, n);
    $display("test reset done");
    for (int i = 1; i < 40; i++) begin
      if (i < 10) step(ops[i], cor[i]);
      else step(ops[$urandom_range(0, 9)], 8'($urandom));
    end
    $display("test instruction stream done");
    for (int m = 0; m < 2; m++) begin
      step(cbe_pkg::OP_BR_ZS, 8'h04);
      mon = m[0];
      // Second pass raises the request in the branch's last cycle
      if (m == 1) @(negedge core_clk_i);
      arm = 1'h1;
      snap();
      pk = {sf, sa, shx[7:0], spc};
      gen(cbe_pkg::OP_ADD_IMM, 8'($urandom));
      hnd = m ? 16'h4010 : 16'h4000;
      prt.mem[m ? cbe_pkg::VEC_TRAP_MON : cbe_pkg::VEC_TRAP] = hnd[15:8];
      prt.mem[m ? 16'hFEFD : 16'hFFFD] = hnd[7:0];
      prt.mem[hnd] = cbe_pkg::OP_RET_TRAP;
      @(negedge core_clk_i);
      arm = 1'h0;
      wait_until(0, n);
      wait_until(1, n);
      for (int k = 0; k < 5; k++) begin
        chk({8'h00, prt.mem[ssp - 16'(k)]}, {8'h00, pk[8*k +: 8]}, "stacked byte");
      end
      chk(stack_pointer_o, ssp - 16'h0005, "sp after stacking");
      chk({15'h0000, condition_flags_o[cbe_pkg::FLG_I]}, 16'h0001, "mask");
      wait_until(2, n);
      chk({15'h0000, insn_done_o}, 16'h0001, "return done");
      chk(mem_addr_o, spc, "resume pc");
      chk({acc_o, condition_flags_o}, {sa, sf}, "restored acc and flags");
      chk(stack_pointer_o, ssp, "restored sp");
      $display("test break pass %0d done", m);
    end
    step(cbe_pkg::OP_IDX_SADD, 8'h00);
    print_verdict();
  end
endmodule
bind cbe_core cbe_monitor chk_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .mem_addr_o(mem_addr_o), .mem_wr_o(mem_wr_o), .mem_rdata_i(mem_rdata_i),
  .brk_req_i(brk_req_i), .monitor_mode_i(monitor_mode_i), .brk_active_o(brk_active_o),
  .acc_o(acc_o), .index_pair_o(index_pair_o), .stack_pointer_o(stack_pointer_o),
  .condition_flags_o(condition_flags_o), .insn_done_o(insn_done_o));
`default_nettype wire
